// >>> hdl/lpic_pkg.sv
package lpic_pkg;
    // lines per controller unit and lines offered to the board
    localparam int UNIT_W = 8;
    localparam int EXT_W = 13;
    // i/o port map of the two units
    localparam logic [15:0] MASK_PORT = 16'h0021;
    localparam logic [15:0] CMD_PORT = 16'h0020;
    localparam logic [15:0] SLV_MASK_PORT = 16'h00a1;
    localparam logic [15:0] SLV_CMD_PORT = 16'h00a0;
    // command byte that ends service of the top level in service
    localparam logic [7:0] DONE_CODE = 8'h20;
    // reset value of both masks: everything blocked until software opens lines
    localparam logic [7:0] MASK_RST = 8'hff;
    // vector bases, arbitrary plain defaults
    localparam logic [7:0] VEC_BASE_M = 8'h20;
    localparam logic [7:0] VEC_BASE_S = 8'h28;
    // master line that carries the slave unit
    localparam logic [2:0] CASCADE_LINE = 3'd2;
    // vector offset answered when nothing is pending at acknowledge
    localparam logic [2:0] SPURIOUS_LINE = 3'd7;
    // least request spacing kept by the peripherals
    localparam int CLK_NS = 8;
    localparam int REQ_GAP_NS = 125;
    localparam int REQ_GAP_CYC = (REQ_GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage

// >>> hdl/lpic_top.sv
`timescale 1ns/1ps
// Function
// (R01) a rising request edge on an open, winning line interrupts the processor
// (R02) on acknowledge the block returns an 8-bit vector naming the winner
// (R03) line zero ranks highest, line seven lowest
// (R04) higher request preempts active service; others wait for it to end
// (R05) mask bit n at one blocks line n, at zero lets it through
// (R06) mask register read and written at i/o port 21h
// (R07) service software sends the service-done command before leaving
// (R08) lines from PCI devices are level sensitive, pending while held
// (R09) peripherals space successive requests by at least 125 ns
// (R10) two cascaded units offer 13 usable request lines
// (R11) each unit takes eight separate request lines
// (R12) one level line may be shared by several PCI devices
// (R13) service-done clears the highest level in service
module lpic_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [lpic_pkg::EXT_W-1:0] request_line_n,
    input wire logic [lpic_pkg::EXT_W-1:0] level_sel,
    input wire logic [15:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_wr,
    input wire logic io_rd,
    output logic [7:0] io_rdata,
    input wire logic cpu_ack,
    output logic cpu_intr,
    output logic [7:0] vector,
    output logic vector_valid
);
    import lpic_pkg::*;

    logic [EXT_W-1:0] sync1_ff, sync2_ff;
    logic [7:0] mmask_ff, smask_ff, rdata_ff, vector_ff;
    logic intr_ff, valid_ff;
    logic [7:0] nxt_mmask, nxt_smask, nxt_rdata, nxt_vector;
    logic nxt_intr, nxt_valid;
    logic [7:0] m_req, m_lvl, s_req, s_lvl, m_irr, m_isr, s_irr, s_isr;
    logic m_intr, s_intr, m_ack, s_ack, m_done, s_done;
    logic [2:0] m_win, s_win;

    // request pins cross into mclk through two flops before any logic looks at them; level_sel is used unsynchronised
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sync1_ff <= '0;
            sync2_ff <= '0;
        end else begin
            sync1_ff <= request_line_n;
            sync2_ff <= sync1_ff;
        end
    end

    // (R10) line map: master 0,1,3..7 and slave 0..5; master 2 carries slave
    always_comb begin
        // the slave decision is already on mclk, so the cascade bit skips the sync
        m_req = {sync2_ff[6:2], s_intr, sync2_ff[1:0]};
        // cascade is a level so the slave keeps asking until served
        m_lvl = {level_sel[6:2], 1'b1, level_sel[1:0]};
        s_req = {2'b00, sync2_ff[12:7]};
        // (R12) shared lines are level mode, held while any source asks
        s_lvl = {2'b00, level_sel[12:7]};
    end

    // (R11) eight lines per unit
    lpic_unit u_master (
        .mclk(mclk),
        .rst_n(rst_n),
        .req(m_req),
        .level(m_lvl),
        .mask(mmask_ff),
        .ack(m_ack),
        .done(m_done),
        .pend(m_irr),
        .serv(m_isr),
        .intr(m_intr),
        .win(m_win)
    );

    lpic_unit u_slave (
        .mclk(mclk),
        .rst_n(rst_n),
        .req(s_req),
        .level(s_lvl),
        .mask(smask_ff),
        .ack(s_ack),
        .done(s_done),
        .pend(s_irr),
        .serv(s_isr),
        .intr(s_intr),
        .win(s_win)
    );

    // port decode, acknowledge routing and vector choice
    always_comb begin
        nxt_mmask = mmask_ff;
        nxt_smask = smask_ff;
        // (R06) mask writes at the mask ports
        if (io_wr && io_addr == MASK_PORT) begin
            nxt_mmask = io_wdata;
        end
        if (io_wr && io_addr == SLV_MASK_PORT) begin
            nxt_smask = io_wdata;
        end
        // (R07) service-done command accepted per unit
        m_done = io_wr && io_addr == CMD_PORT && io_wdata == DONE_CODE;
        s_done = io_wr && io_addr == SLV_CMD_PORT && io_wdata == DONE_CODE;
        // ack only lands on a unit that really asks; else spurious vector
        m_ack = cpu_ack && m_intr;
        s_ack = m_ack && m_win == CASCADE_LINE && s_intr;
        // (R02) vector names the winning line
        nxt_vector = vector_ff;
        if (cpu_ack) begin
            if (!m_intr) begin
                nxt_vector = VEC_BASE_M + {5'b00000, SPURIOUS_LINE};
            end else if (m_win != CASCADE_LINE) begin
                nxt_vector = VEC_BASE_M + {5'b00000, m_win};
            end else if (s_intr) begin
                nxt_vector = VEC_BASE_S + {5'b00000, s_win};
            end else begin
                nxt_vector = VEC_BASE_S + {5'b00000, SPURIOUS_LINE};
            end
        end
        nxt_valid = cpu_ack;
        // dropped on acknowledge so the host cannot fetch the same level twice
        // (R01) interrupt line follows the master decision
        nxt_intr = m_intr && !cpu_ack;
        // read data is held until the next read
        nxt_rdata = rdata_ff;
        if (io_rd) begin
            unique case (io_addr)
                MASK_PORT: nxt_rdata = mmask_ff;
                SLV_MASK_PORT: nxt_rdata = smask_ff;
                CMD_PORT: nxt_rdata = m_isr;
                SLV_CMD_PORT: nxt_rdata = s_isr;
                default: nxt_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mmask_ff <= MASK_RST;
            smask_ff <= MASK_RST;
            rdata_ff <= 8'h00;
            vector_ff <= 8'h00;
            valid_ff <= 1'b0;
            intr_ff <= 1'b0;
        end else begin
            mmask_ff <= nxt_mmask;
            smask_ff <= nxt_smask;
            rdata_ff <= nxt_rdata;
            vector_ff <= nxt_vector;
            valid_ff <= nxt_valid;
            intr_ff <= nxt_intr;
        end
    end

    assign io_rdata = rdata_ff;
    assign vector = vector_ff;
    assign vector_valid = valid_ff;
    assign cpu_intr = intr_ff;

    // pin sync, register port and vector checks
    pin_sync_a: // (R11)
        assert property (@(posedge mclk) disable iff (!rst_n)
            $past(rst_n, 2) |-> (sync2_ff == $past(request_line_n, 2)))
        else $error("request pin not seen two cycles later");
    mask_write_a: // (R06)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (io_wr && io_addr == MASK_PORT) |=> (mmask_ff == $past(io_wdata)))
        else $error("mask write not stored");
    mask_read_a: // (R06)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (io_rd && io_addr == MASK_PORT && !io_wr) |=> (io_rdata == mmask_ff))
        else $error("mask read returns wrong value");
    vec_answer_a: // (R02)
        assert property (@(posedge mclk) disable iff (!rst_n)
            cpu_ack |=> vector_valid ##1 (!vector_valid || $past(cpu_ack)))
        else $error("vector strobe not one cycle after acknowledge");
    cascade_vec_a: // (R10)
        assert property (@(posedge mclk) disable iff (!rst_n)
            s_ack |=> (vector == VEC_BASE_S + {5'b00000, $past(s_win)}))
        else $error("slave vector wrong");
    master_vec_a: // (R03)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (m_ack && m_win != CASCADE_LINE) |=> (vector == VEC_BASE_M + {5'b00000, $past(m_win)}))
        else $error("master vector wrong");

    // interrupt line, spurious vector, held outputs and slave mask write checks
    intr_drop_a: // (R01)
        assert property (@(posedge mclk) disable iff (!rst_n)
            cpu_ack |=> !cpu_intr)
        else $error("interrupt line still up after acknowledge");
    intr_rise_a: // (R01)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (m_intr && !cpu_ack) |=> cpu_intr)
        else $error("interrupt line missed an eligible request");
    vec_hold_a: // (R02)
        assert property (@(posedge mclk) disable iff (!rst_n)
            !cpu_ack |=> $stable(vector))
        else $error("vector changed without acknowledge");
    spur_vec_a: // (R02)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (cpu_ack && !m_intr) |=> (vector == VEC_BASE_M + {5'b00000, SPURIOUS_LINE}))
        else $error("spurious acknowledge gave wrong vector");
    smask_write_a: // (R05)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (io_wr && io_addr == SLV_MASK_PORT) |=> (smask_ff == $past(io_wdata)))
        else $error("slave mask write not stored");
    rdata_hold_a: // (R06)
        assert property (@(posedge mclk) disable iff (!rst_n)
            !io_rd |=> $stable(io_rdata))
        else $error("read data changed without a read");

    // main scenarios the bench should reach
    nest_cov: cover property (@(posedge mclk) disable iff (!rst_n)
        m_ack && m_isr != 8'h00);
    cascade_cov: cover property (@(posedge mclk) disable iff (!rst_n) s_ack);
    done_cov: cover property (@(posedge mclk) disable iff (!rst_n)
        m_done && m_isr != 8'h00);
    spur_cov: cover property (@(posedge mclk) disable iff (!rst_n) cpu_ack && !m_intr);
    level_cov: cover property (@(posedge mclk) disable iff (!rst_n)
        m_ack && m_win != CASCADE_LINE && m_lvl[m_win]);
endmodule

// >>> hdl/lpic_unit.sv
`timescale 1ns/1ps
module lpic_unit (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [lpic_pkg::UNIT_W-1:0] req,
    input wire logic [lpic_pkg::UNIT_W-1:0] level,
    input wire logic [lpic_pkg::UNIT_W-1:0] mask,
    input wire logic ack,
    input wire logic done,
    output logic [lpic_pkg::UNIT_W-1:0] pend,
    output logic [lpic_pkg::UNIT_W-1:0] serv,
    output logic intr,
    output logic [2:0] win
);
    import lpic_pkg::*;

    // index of the highest priority set bit, line zero first
    function automatic logic [2:0] first_set(input logic [7:0] v);
        logic [2:0] idx;
        idx = 3'd7;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                idx = 3'(i);
            end
        end
        return idx;
    endfunction

    logic [7:0] req_prev_ff, irr_ff, isr_ff;
    logic [7:0] nxt_req_prev, nxt_irr, nxt_isr;
    logic [7:0] live, edge_set, ack_clr, done_clr;
    logic [2:0] srv_top;

    // request, in-service and priority resolution
    always_comb begin
        // (R05) mask gates lines
        live = irr_ff & ~mask;
        // (R03) lowest line wins
        win = first_set(live);
        srv_top = first_set(isr_ff);
        // (R04) only higher priority nests
        intr = (live != 8'h00) && ((isr_ff == 8'h00) || (win < srv_top));
        // (R01) rising edge latches
        edge_set = req & ~req_prev_ff & ~level;
        ack_clr = ack ? (8'h01 << win) : 8'h00;
        // (R13) retire top in-service level
        done_clr = (done && isr_ff != 8'h00) ? (8'h01 << srv_top) : 8'h00;
        nxt_req_prev = req;
        // (R08) level lines follow pin; a new edge beats an ack clear
        nxt_irr = (irr_ff & ~ack_clr & ~level) | edge_set | (req & level);
        // ack set beats a done clear in the same cycle
        nxt_isr = (isr_ff & ~done_clr) | ack_clr;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            req_prev_ff <= 8'h00;
            irr_ff <= 8'h00;
            isr_ff <= 8'h00;
        end else begin
            req_prev_ff <= nxt_req_prev;
            irr_ff <= nxt_irr;
            isr_ff <= nxt_isr;
        end
    end

    assign pend = irr_ff;
    assign serv = isr_ff;

    mask_blocks_a: // (R05)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (live == 8'h00) |-> !intr)
        else $error("interrupt raised with no unmasked request");
    edge_catch_a: // (R01)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (edge_set != 8'h00) |=> ((irr_ff & $past(edge_set)) == $past(edge_set)))
        else $error("rising edge not latched");
    prio_order_a: // (R03)
        assert property (@(posedge mclk) disable iff (!rst_n)
            intr |-> ((live & ((8'h01 << win) - 8'h01)) == 8'h00))
        else $error("winner is not the lowest pending line");
    nest_only_a: // (R04)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (intr && isr_ff != 8'h00) |-> (win < srv_top))
        else $error("equal or lower request preempted service");
    grant_mark_a: // (R02)
        assert property (@(posedge mclk) disable iff (!rst_n)
            ack |=> isr_ff[$past(win)])
        else $error("acknowledged line not in service");
    done_clear_a: // (R13)
        assert property (@(posedge mclk) disable iff (!rst_n)
            (done && !ack && isr_ff != 8'h00) |=> !isr_ff[$past(srv_top)])
        else $error("service done left top level in service");
    level_follow_a: // (R08)
        assert property (@(posedge mclk) disable iff (!rst_n)
            1'b1 |=> ((irr_ff & $past(level)) == ($past(req) & $past(level))))
        else $error("level request does not follow its line");
endmodule

// >>> verification/lpic_host_model.sv
`timescale 1ns/1ps
// processor side: fetches a vector when intr is up, after a chosen wait
module lpic_host_model (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic ack_en,
    input wire logic [3:0] ack_wait,
    input wire logic cpu_intr,
    input wire logic [7:0] vector,
    input wire logic vector_valid,
    output logic cpu_ack,
    output logic [7:0] last_vec,
    output int n_vec
);
    // one fetch at a time; ack is held a single cycle like the real bus cycle
    initial begin
        cpu_ack = 1'b0;
        last_vec = 8'h00;
        n_vec = 0;
        forever begin
            @(posedge mclk);
            #1;
            if (rst_n === 1'b1 && ack_en && cpu_intr === 1'b1) begin
                // each wait step lands off the edge, like every other host change
                repeat (ack_wait) begin
                    @(posedge mclk);
                    #1;
                end
                cpu_ack = 1'b1;
                @(posedge mclk);
                #1;
                cpu_ack = 1'b0;
                if (vector_valid === 1'b1) begin
                    last_vec = vector;
                    n_vec++;
                end
            end
        end
    end
endmodule

// >>> verification/lpic_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module lpic_top_tb;
    import lpic_pkg::*;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic [EXT_W-1:0] req = '0;
    logic [EXT_W-1:0] lvl = '0;
    logic [15:0] io_addr = 16'h0000;
    logic [7:0] io_wdata = 8'h00;
    logic io_wr = 1'b0;
    logic io_rd = 1'b0;
    logic [7:0] io_rdata, vector, last_vec;
    logic cpu_ack, cpu_intr, vector_valid;
    logic ack_en = 1'b1;
    logic [3:0] ack_wait = 4'h0;
    int n_vec, seen = 0, fail_count = 0, n_checks = 0;
    // expected vector for each board line, indexed by line
    logic [7:0] row_vec [13] = '{8'h20, 8'h21, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27,
        8'h28, 8'h29, 8'h2a, 8'h2b, 8'h2c, 8'h2d};

    always #4 mclk = ~mclk;

    lpic_top uut (.mclk(mclk), .rst_n(rst_n), .request_line_n(req), .level_sel(lvl),
        .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd),
        .io_rdata(io_rdata), .cpu_ack(cpu_ack), .cpu_intr(cpu_intr), .vector(vector),
        .vector_valid(vector_valid));
    lpic_host_model host (.mclk(mclk), .rst_n(rst_n), .ack_en(ack_en), .ack_wait(ack_wait),
        .cpu_intr(cpu_intr), .vector(vector), .vector_valid(vector_valid),
        .cpu_ack(cpu_ack), .last_vec(last_vec), .n_vec(n_vec));

    // all stimulus lands 1 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one strobe cycle, then an idle cycle so strobes never toggle twice at once
    task automatic bus(input logic [15:0] a, input logic [7:0] d, input logic w);
        io_addr = a;
        io_wdata = d;
        io_wr = w;
        io_rd = !w;
        tick(1);
        io_wr = 1'b0;
        io_rd = 1'b0;
        tick(1);
    endtask
    task automatic done(input logic slv);
        if (slv) bus(SLV_CMD_PORT, DONE_CODE, 1'b1);
        bus(CMD_PORT, DONE_CODE, 1'b1);
    endtask
    // bounded wait for the next fetched vector
    task automatic get_vec(input logic [7:0] e);
        repeat (60) if (n_vec == seen) tick(1);
        seen++;
        `CHK("vec_count", seen, n_vec)
        `CHK("vector", e, last_vec)
    endtask
    task automatic quiet;
        tick(20);
        `CHK("vec_count", seen, n_vec)
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // watchdog far beyond the several hundred cycles the tests need
    initial begin
        #100000;
        fail_count++;
        tally_and_finish;
    end

    initial begin
        tick(3);
        rst_n = 1'b1;
        bus(MASK_PORT, 8'h00, 1'b0);
        `CHK("mask_reset", MASK_RST, io_rdata)
        `CHK("intr_reset", 1'b0, cpu_intr)
        bus(MASK_PORT, 8'h00, 1'b1);
        bus(SLV_MASK_PORT, 8'h00, 1'b1);
        bus(MASK_PORT, 8'h00, 1'b0);
        `CHK("mask_rw", 8'h00, io_rdata)
        bus(SLV_MASK_PORT, 8'h00, 1'b0);
        `CHK("smask_rw", 8'h00, io_rdata)
        $display("test reset done");
        // every board line once, each ended by the service-done command
        for (int i = 0; i < EXT_W; i++) begin
            req[i] = 1'b1;
            get_vec(row_vec[i]);
            req[i] = 1'b0;
            done(i >= 7);
            bus(CMD_PORT, 8'h00, 1'b0);
            `CHK("in_service", 8'h00, io_rdata)
            bus(SLV_CMD_PORT, 8'h00, 1'b0);
            `CHK("slv_service", 8'h00, io_rdata)
            tick(16);
        end
        $display("test rows done");
        // two at once: the lower number wins, the other waits
        ack_en = 1'b0;
        req[5] = 1'b1;
        req[1] = 1'b1;
        tick(8);
        `CHK("intr_up", 1'b1, cpu_intr)
        ack_en = 1'b1;
        ack_wait = 4'h5;
        get_vec(8'h21);
        done(1'b0);
        get_vec(8'h26);
        req = '0;
        done(1'b0);
        $display("test priority done");
        // nesting: higher preempts, lower waits behind the level in service
        ack_wait = 4'h0;
        req[4] = 1'b1;
        get_vec(8'h25);
        tick(16);
        req[0] = 1'b1;
        get_vec(8'h20);
        tick(16);
        req[6] = 1'b1;
        done(1'b0);
        bus(CMD_PORT, 8'h00, 1'b0);
        `CHK("in_service", 8'h20, io_rdata)
        quiet();
        done(1'b0);
        get_vec(8'h27);
        done(1'b0);
        req = '0;
        $display("test nesting done");
        // masked line stays silent until opened
        tick(16);
        bus(MASK_PORT, 8'h02, 1'b1);
        req[1] = 1'b1;
        quiet();
        bus(MASK_PORT, 8'h00, 1'b1);
        get_vec(8'h21);
        done(1'b0);
        req[1] = 1'b0;
        $display("test mask done");
        // line masked while the host waits: the fetch finds nothing and gets the spare vector
        tick(16);
        ack_wait = 4'h8;
        req[2] = 1'b1;
        tick(5);
        bus(MASK_PORT, 8'h08, 1'b1);
        get_vec(VEC_BASE_M + {5'b00000, SPURIOUS_LINE});
        ack_wait = 4'h0;
        bus(MASK_PORT, 8'h00, 1'b1);
        get_vec(8'h23);
        done(1'b0);
        req[2] = 1'b0;
        $display("test spurious done");
        // level line held high asks again after each service-done
        tick(16);
        lvl[3] = 1'b1;
        req[3] = 1'b1;
        get_vec(8'h24);
        quiet();
        done(1'b0);
        get_vec(8'h24);
        req[3] = 1'b0;
        tick(4);
        done(1'b0);
        quiet();
        // slave line in level mode asks again through the cascade until its pin drops
        lvl[9] = 1'b1;
        req[9] = 1'b1;
        get_vec(8'h2a);
        done(1'b1);
        get_vec(8'h2a);
        req[9] = 1'b0;
        tick(4);
        done(1'b1);
        quiet();
        bus(16'h0030, 8'h00, 1'b0);
        `CHK("unmapped", 8'h00, io_rdata)
        $display("test level done");
        // reset in mid-run: masks back to blocked, outputs cleared
        bus(MASK_PORT, 8'h5a, 1'b1);
        rst_n = 1'b0;
        tick(3);
        rst_n = 1'b1;
        `CHK("valid_reset", 1'b0, vector_valid)
        `CHK("vec_reset", 8'h00, vector)
        bus(MASK_PORT, 8'h00, 1'b0);
        `CHK("mask_reset", MASK_RST, io_rdata)
        `CHK("intr_reset", 1'b0, cpu_intr)
        $display("test reset again done");
        tally_and_finish;
    end
endmodule
